// file: rtl/scs_pkg.sv
// Constants and types shared by the system clock switch.
// How it works
// - Select 00 runs the configured default oscillator.
// - Select 01 runs the secondary crystal oscillator.
// - Select 1x runs internal oscillator at chosen frequency.
// - Chosen clock feeds CPU and peripherals alike.
// - Every reset clears the select field.
// - Automatic switches never alter the select field.
// - Status bit shows configured external source running.
// - Crystal modes: status waits for start-up timer.
// - Status bit ignores the secondary oscillator.
// - Secondary oscillator runs only while enable set.
// - Ready bit shows secondary oscillator is stable.
// - New source must be stable before use.
package scs_pkg;

  // Register byte offsets on the bus.
  localparam logic [3:0] OFS_OSC_CTRL  = 4'h0;
  localparam logic [3:0] OFS_OSC_STAT  = 4'h4;
  localparam logic [3:0] OFS_T1_CTRL   = 4'h8;

  // Field positions.
  localparam int CTRL_SCS_LSB   = 0;
  localparam int CTRL_FREQ_LSB  = 3;
  localparam int STAT_START_BIT = 0;
  localparam int STAT_SRDY_BIT  = 1;
  localparam int STAT_FAIL_BIT  = 2;
  localparam int STAT_ACT_LSB   = 4;
  localparam int T1_SOSCEN_BIT  = 3;

  // Reset values.
  localparam logic [1:0] SCS_RESET  = 2'h0;
  localparam logic [3:0] FREQ_RESET = 4'h7;

  // Source numbers used by the multiplexer.
  typedef enum logic [1:0] {
    SRC_PRIMARY   = 2'b00,
    SRC_SECONDARY = 2'b01,
    SRC_INTERNAL  = 2'b10
  } scs_src_type;

  // Configured oscillator codes.
  localparam logic [2:0] CFG_LOW_POWER  = 3'h0;
  localparam logic [2:0] CFG_STANDARD   = 3'h1;
  localparam logic [2:0] CFG_HIGH_SPEED = 3'h2;
  localparam logic [2:0] CFG_INTERNAL   = 3'h4;

  // Timing.
  localparam int CLK_PERIOD_NS        = 50;
  localparam int STARTUP_EDGES        = 1024;
  localparam int SOSC_READY_EDGES     = 1024;
  localparam int INT_STABLE_NS        = 1000;
  localparam int INT_STABLE_CYCLES    = (INT_STABLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FSCM_TIMEOUT_NS      = 3200;
  localparam int FSCM_TIMEOUT_CYCLES  = FSCM_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam logic [4:0] INT_HALF_BASE = 5'h10;

endpackage : scs_pkg

// file: rtl/scs_mux_if.sv
// Connection between the switch controller and the glitch-free multiplexer.
interface scs_mux_if;
  logic [2:0] srcClk;
  logic [2:0] srcOk;
  logic [1:0] reqSrc;
  logic [1:0] activeSrc;
  logic       sysClk;
  logic       busy;

  modport ctrl (output srcClk, output srcOk, output reqSrc, input activeSrc, input sysClk, input busy);
  modport mux  (input srcClk, input srcOk, input reqSrc, output activeSrc, output sysClk, output busy);
endinterface : scs_mux_if

// file: rtl/scs_clock_mux.sv
// Glitch-free selection among the sampled clock sources.
module scs_clock_mux (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Controller side.
  scs_mux_if.mux   bus
);

  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_DROP = 2'b01,
    ST_PICK = 2'b10
  } scs_mux_state_type;

  scs_mux_state_type stateReg;
  logic [1:0]        curReg;
  logic [1:0]        tgtReg;
  logic              enReg;
  logic              sysClkReg;

  wire logic curLow  = ~bus.srcClk[curReg];
  wire logic curOk   = bus.srcOk[curReg];
  wire logic wantNew = (bus.reqSrc != curReg) && bus.srcOk[bus.reqSrc];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stateReg <= ST_PICK;
      curReg   <= scs_pkg::SRC_INTERNAL;
      tgtReg   <= scs_pkg::SRC_INTERNAL;
      enReg    <= 1'b0;
    end else begin
      case (stateReg)
        ST_RUN: begin
          if (wantNew) begin
            tgtReg   <= bus.reqSrc;
            stateReg <= ST_DROP;
          end
        end
        ST_DROP: begin
          if (curLow) begin
            enReg    <= 1'b0;
            curReg   <= tgtReg;
            stateReg <= ST_PICK;
          end
        end
        ST_PICK: begin
          if (bus.reqSrc != curReg && bus.srcOk[bus.reqSrc]) begin
            curReg <= bus.reqSrc;
          end else if (curOk && curLow) begin
            enReg    <= 1'b1;
            stateReg <= ST_RUN;
          end
        end
        default: stateReg <= ST_PICK;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sysClkReg <= 1'b0;
    end else begin
      sysClkReg <= enReg & bus.srcClk[curReg];
    end
  end

  assign bus.sysClk    = sysClkReg;
  assign bus.activeSrc = curReg;
  assign bus.busy      = (stateReg != ST_RUN);

  chk_gate_when_low: assert property (@(posedge core_clk) disable iff (rst)
    $changed(enReg) |-> $past(curLow))
    else $error("gate changed while the clock was high");

  chk_enable_stable_src: assert property (@(posedge core_clk) disable iff (rst)
    $rose(enReg) |-> $past(curOk))
    else $error("source enabled before it was stable");

  chk_out_only_gated: assert property (@(posedge core_clk) disable iff (rst)
    bus.sysClk |-> $past(enReg) && !$past(curLow))
    else $error("system clock high without a gated source");

  cov_switch_done: cover property (@(posedge core_clk) disable iff (rst)
    stateReg == ST_DROP ##[1:200] stateReg == ST_RUN);

endmodule : scs_clock_mux

// file: rtl/scs_system_clock_switch.sv
// System clock switch with its register slave, oscillator monitors and start-up logic.
module scs_system_clock_switch (
  // Clock and reset.
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Register bus.
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Configuration straps.
  input  wire logic [2:0]  configOscillatorSelect,
  input  wire logic        twoSpeedEnable,
  input  wire logic        failSafeEnable,
  // Oscillator pins.
  input  wire logic        primaryOscIn,
  input  wire logic        secondaryOscInPin,
  output logic             secondaryOscOutPinEn,
  // System clock.
  output logic             cpuClk,
  output logic             periphClk
);

  scs_mux_if muxBus ();

  // Pin synchronisers with agreement filter.
  logic [1:0] pinRaw;
  logic [1:0] sync1Reg;
  logic [1:0] sync2Reg;
  logic [1:0] sync3Reg;
  logic [1:0] lvlReg;
  logic [1:0] lvlPrevReg;
  assign pinRaw = {secondaryOscInPin, primaryOscIn};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : gSync
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          sync1Reg[gi]   <= 1'b0;
          sync2Reg[gi]   <= 1'b0;
          sync3Reg[gi]   <= 1'b0;
          lvlReg[gi]     <= 1'b0;
          lvlPrevReg[gi] <= 1'b0;
        end else begin
          sync1Reg[gi]   <= pinRaw[gi];
          sync2Reg[gi]   <= sync1Reg[gi];
          sync3Reg[gi]   <= sync2Reg[gi];
          lvlPrevReg[gi] <= lvlReg[gi];
          if (sync2Reg[gi] == sync3Reg[gi]) begin
            lvlReg[gi] <= sync3Reg[gi];
          end
        end
      end
    end
  endgenerate

  wire logic [1:0] riseEdge = lvlReg & ~lvlPrevReg;

  // Strap capture after reset release.
  logic [2:0] cfgReg;
  logic       cfgLoadedReg;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfgReg       <= scs_pkg::CFG_INTERNAL;
      cfgLoadedReg <= 1'b0;
    end else if (!cfgLoadedReg) begin
      cfgReg       <= configOscillatorSelect;
      cfgLoadedReg <= 1'b1;
    end
  end

  wire logic cfgInternal = (cfgReg == scs_pkg::CFG_INTERNAL);
  wire logic cfgCrystal  = (cfgReg == scs_pkg::CFG_LOW_POWER) || (cfgReg == scs_pkg::CFG_STANDARD) ||
                           (cfgReg == scs_pkg::CFG_HIGH_SPEED);

  // Register file and bus slave.
  logic [1:0]  scsReg;
  logic [3:0]  freqSelReg;
  logic        soscEnReg;
  logic        ackReg;
  logic [31:0] rdDataReg;

  wire logic access   = avs_read | avs_write;
  wire logic doWrite  = avs_write & ackReg & avs_byteenable[0];
  wire logic hitCtrl  = (avs_address == scs_pkg::OFS_OSC_CTRL);
  wire logic hitStat  = (avs_address == scs_pkg::OFS_OSC_STAT);
  wire logic hitT1    = (avs_address == scs_pkg::OFS_T1_CTRL);
  wire logic wrCtrl   = doWrite & hitCtrl;
  wire logic wrT1     = doWrite & hitT1;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ackReg <= 1'b0;
    end else begin
      ackReg <= access & ~ackReg;
    end
  end
  assign avs_waitrequest = access & ~ackReg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scsReg    <= scs_pkg::SCS_RESET;
      freqSelReg <= scs_pkg::FREQ_RESET;
      soscEnReg <= 1'b0;
    end else begin
      if (wrCtrl) begin
        scsReg  <= avs_writedata[scs_pkg::CTRL_SCS_LSB +: 2];
        freqSelReg <= avs_writedata[scs_pkg::CTRL_FREQ_LSB +: 4];
      end
      if (wrT1) begin
        soscEnReg <= avs_writedata[scs_pkg::T1_SOSCEN_BIT];
      end
    end
  end

  // Start-up timer on the configured external source.
  logic [10:0] startCntReg;
  logic        startDoneReg;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      startCntReg  <= 11'h000;
      startDoneReg <= 1'b0;
    end else if (cfgLoadedReg && !startDoneReg) begin
      if (!cfgCrystal) begin
        startDoneReg <= 1'b1;
      end else if (riseEdge[0]) begin
        startCntReg <= startCntReg + 11'h001;
        if (startCntReg == 11'(scs_pkg::STARTUP_EDGES - 1)) begin
          startDoneReg <= 1'b1;
        end
      end
    end
  end

  // Fail-safe monitor: primary silent too long after start-up.
  logic [7:0] silentCntReg;
  logic       failedReg;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      silentCntReg <= 8'h00;
      failedReg    <= 1'b0;
    end else begin
      if (riseEdge[0]) begin
        silentCntReg <= 8'h00;
      end else if (silentCntReg != 8'hFF) begin
        silentCntReg <= silentCntReg + 8'h01;
      end
      if (failSafeEnable && startDoneReg && !cfgInternal &&
          silentCntReg >= 8'(scs_pkg::FSCM_TIMEOUT_CYCLES)) begin
        failedReg <= 1'b1;
      end
    end
  end

  // Secondary oscillator readiness.
  logic [10:0] soscCntReg;
  logic        soscReadyReg;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      soscCntReg   <= 11'h000;
      soscReadyReg <= 1'b0;
    end else if (!soscEnReg) begin
      soscCntReg   <= 11'h000;
      soscReadyReg <= 1'b0;
    end else if (riseEdge[1] && !soscReadyReg) begin
      soscCntReg <= soscCntReg + 11'h001;
      if (soscCntReg == 11'(scs_pkg::SOSC_READY_EDGES - 1)) begin
        soscReadyReg <= 1'b1;
      end
    end
  end
  assign secondaryOscOutPinEn = soscEnReg;

  // Internal oscillator block: divider of the core clock.
  logic [4:0] intDivReg;
  logic       intClkReg;
  logic [4:0] intStableReg;
  wire logic [4:0] halfLen = scs_pkg::INT_HALF_BASE - {1'b0, freqSelReg};
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      intDivReg    <= 5'h00;
      intClkReg    <= 1'b0;
      intStableReg <= 5'h00;
    end else begin
      if (intDivReg >= halfLen - 5'h01) begin
        intDivReg <= 5'h00;
        intClkReg <= ~intClkReg;
      end else begin
        intDivReg <= intDivReg + 5'h01;
      end
      if (intStableReg != 5'(scs_pkg::INT_STABLE_CYCLES)) begin
        intStableReg <= intStableReg + 5'h01;
      end
    end
  end
  wire logic intStable = (intStableReg == 5'(scs_pkg::INT_STABLE_CYCLES));

  // Source request; automatic fallbacks act here, never on the select field.
  wire logic autoInternal = cfgInternal || failedReg || (twoSpeedEnable && !startDoneReg);
  wire logic [1:0] reqSrc = scsReg[1]            ? scs_pkg::SRC_INTERNAL :
                            (scsReg == 2'h1)     ? scs_pkg::SRC_SECONDARY :
                            autoInternal         ? scs_pkg::SRC_INTERNAL :
                                                   scs_pkg::SRC_PRIMARY;

  assign muxBus.reqSrc = reqSrc;
  assign muxBus.srcClk = {intClkReg, lvlReg[1], lvlReg[0]};
  // The mux waits for readiness, so an early secondary selection only stalls.
  assign muxBus.srcOk  = {intStable, soscReadyReg, startDoneReg & ~failedReg & cfgLoadedReg};

  scs_clock_mux u_mux (
    .core_clk (core_clk),
    .rst      (rst),
    .bus      (muxBus)
  );

  assign cpuClk    = muxBus.sysClk;
  assign periphClk = muxBus.sysClk;

  // Status: external configured source running after its start-up timer.
  wire logic startStatus = (muxBus.activeSrc == scs_pkg::SRC_PRIMARY) && !muxBus.busy &&
                           startDoneReg && !cfgInternal;

  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    if (hitCtrl) begin
      rdMux[scs_pkg::CTRL_SCS_LSB +: 2]  = scsReg;
      rdMux[scs_pkg::CTRL_FREQ_LSB +: 4] = freqSelReg;
    end else if (hitStat) begin
      rdMux[scs_pkg::STAT_START_BIT]     = startStatus;
      rdMux[scs_pkg::STAT_SRDY_BIT]      = soscReadyReg;
      rdMux[scs_pkg::STAT_FAIL_BIT]      = failedReg;
      rdMux[scs_pkg::STAT_ACT_LSB +: 2]  = muxBus.activeSrc;
    end else if (hitT1) begin
      rdMux[scs_pkg::T1_SOSCEN_BIT]      = soscEnReg;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdDataReg <= 32'h0000_0000;
    end else if (avs_read && !ackReg) begin
      rdDataReg <= rdMux;
    end
  end
  assign avs_readdata = rdDataReg;

  chk_reset_clears_scs: assert property (@(posedge core_clk)
    $fell(rst) |-> scsReg == scs_pkg::SCS_RESET)
    else $error("select field not cleared by reset");

  chk_scs_only_by_write: assert property (@(posedge core_clk) disable iff (rst)
    !$past(wrCtrl) |-> $stable(scsReg))
    else $error("select field changed without a register write");

  chk_default_source: assert property (@(posedge core_clk) disable iff (rst)
    scsReg == 2'h0 && !cfgInternal && startDoneReg && !failedReg && cfgLoadedReg
    |-> reqSrc == scs_pkg::SRC_PRIMARY)
    else $error("default source not requested");

  chk_secondary_code: assert property (@(posedge core_clk) disable iff (rst)
    scsReg == 2'h1 |-> reqSrc == scs_pkg::SRC_SECONDARY)
    else $error("secondary code did not request the secondary source");

  chk_internal_code: assert property (@(posedge core_clk) disable iff (rst)
    scsReg[1] |-> reqSrc == scs_pkg::SRC_INTERNAL)
    else $error("internal code did not request the internal source");

  chk_status_after_timer: assert property (@(posedge core_clk) disable iff (rst)
    cfgCrystal && startStatus |-> startDoneReg && startCntReg == 11'(scs_pkg::STARTUP_EDGES))
    else $error("status set before the start-up timer expired");

  chk_status_not_sec: assert property (@(posedge core_clk) disable iff (rst)
    muxBus.activeSrc == scs_pkg::SRC_SECONDARY |-> !startStatus)
    else $error("status reflects the secondary oscillator");

  chk_sosc_disabled: assert property (@(posedge core_clk) disable iff (rst)
    !soscEnReg |-> !secondaryOscOutPinEn ##1 !soscReadyReg)
    else $error("secondary oscillator active while disabled");

  chk_ready_counts: assert property (@(posedge core_clk) disable iff (rst)
    $rose(soscReadyReg) |-> $past(soscCntReg) == 11'(scs_pkg::SOSC_READY_EDGES - 1))
    else $error("ready bit set before enough secondary edges");

  chk_read_answer: assert property (@(posedge core_clk) disable iff (rst)
    avs_read && !ackReg |=> !avs_waitrequest && avs_readdata == $past(rdMux))
    else $error("read answer not given one cycle after the request");

  cov_status_rise: cover property (@(posedge core_clk) disable iff (rst) $rose(startStatus));
  cov_run_secondary: cover property (@(posedge core_clk) disable iff (rst)
    muxBus.activeSrc == scs_pkg::SRC_SECONDARY && !muxBus.busy);
  cov_fail_safe: cover property (@(posedge core_clk) disable iff (rst) $rose(failedReg));
  cov_internal_sel: cover property (@(posedge core_clk) disable iff (rst) scsReg[1] ##[1:100] !muxBus.busy);

endmodule : scs_system_clock_switch

// file: test/scs_osc_model.sv
// Oscillator sources seen by the clock switch: primary external and secondary crystal.
module scs_osc_model #(
  parameter int PRI_HALF_NS = 200,
  parameter int SEC_HALF_NS = 300
) (
  // Control from the bench and the device.
  input  wire logic primaryStop,
  input  wire logic secondaryOscOutPinEn,
  // Oscillator outputs.
  output logic      primaryOscIn,
  output logic      secondaryOscInPin
);
  timeunit 1ns;
  timeprecision 100ps;

  // The primary source starts out of phase with the core clock; a stopped source rests low.
  initial begin
    primaryOscIn = 1'b0;
    #7;
    forever #(PRI_HALF_NS) primaryOscIn = primaryStop ? 1'b0 : ~primaryOscIn;
  end

  // The crystal only swings while its amplifier is driven.
  initial begin
    secondaryOscInPin = 1'b0;
    #19;
    forever #(SEC_HALF_NS) secondaryOscInPin = secondaryOscOutPinEn ? ~secondaryOscInPin : 1'b0;
  end
endmodule : scs_osc_model

// file: test/scs_system_clock_switch_test.sv
// Self-checking bench for the system clock switch.
module scs_system_clock_switch_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        primaryOscIn;
  logic        secondaryOscInPin;
  logic        secondaryOscOutPinEn;
  logic        cpuClk;
  logic        periphClk;
  logic        primaryStop = 1'b0;
  logic [2:0]  oscCfg = scs_pkg::CFG_STANDARD;
  logic [31:0] rd;
  int          err_count = 0;
  int          samples_checked = 0;
  int          per;
  int          hiCnt = 0;

  always #25 core_clk = ~core_clk;

  scs_system_clock_switch scs_system_clock_switch_inst (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .configOscillatorSelect(oscCfg), .twoSpeedEnable(1'b1), .failSafeEnable(1'b1),
    .primaryOscIn(primaryOscIn), .secondaryOscInPin(secondaryOscInPin),
    .secondaryOscOutPinEn(secondaryOscOutPinEn), .cpuClk(cpuClk), .periphClk(periphClk));

  scs_osc_model scs_osc_model_inst (
    .primaryStop(primaryStop), .secondaryOscOutPinEn(secondaryOscOutPinEn),
    .primaryOscIn(primaryOscIn), .secondaryOscInPin(secondaryOscInPin));

  task automatic wrap_up;
    $display("Checks made: %0d, mismatches: %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  task automatic hung(input string what);
    err_count++;
    $display("ERROR at %0t: wait for %s ran out", $time, what);
    wrap_up();
  endtask : hung

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // One Avalon transfer; the request stands until waitrequest is sampled low.
  task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] wdata,
                     input logic [3:0] be, output logic [31:0] rdata);
    int n = 0;
    @(posedge core_clk);
    avs_address <= addr;
    avs_writedata <= wdata;
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) hung("waitrequest");
  endtask : bus

  task automatic wr(input logic [3:0] addr, input logic [31:0] wdata);
    logic [31:0] d;
    bus(1'b1, addr, wdata, 4'hF, d);
  endtask : wr

  task automatic rdreg(input logic [3:0] addr);
    bus(1'b0, addr, 32'h0000_0000, 4'hF, rd);
  endtask : rdreg

  // Counts core cycles up to the next rising edge of the system clock.
  task automatic wait_rise(output int cnt);
    logic prev;
    prev = cpuClk;
    cnt = 0;
    do begin
      @(posedge core_clk);
      cnt++;
      if (cpuClk === 1'b1 && prev === 1'b0) return;
      prev = cpuClk;
    end while (cnt < 3000);
    hung("system clock edge");
  endtask : wait_rise

  task automatic measure;
    repeat (2) wait_rise(per);
    wait_rise(per);
  endtask : measure

  task automatic poll_status(input int bitPos, input logic val, input int maxReads);
    for (int i = 0; i < maxReads; i++) begin
      rdreg(scs_pkg::OFS_OSC_STAT);
      if (rd[bitPos] === val) return;
    end
    hung("status bit");
  endtask : poll_status

  task automatic check_mode(input logic [1:0] act, input logic startup_timer_status, input logic [1:0] sel);
    rdreg(scs_pkg::OFS_OSC_STAT);
    check(32'(rd[5:4]), 32'(act), "active source");
    check(32'(rd[0]), 32'(startup_timer_status), "start-up status");
    rdreg(scs_pkg::OFS_OSC_CTRL);
    check(32'(rd[1:0]), 32'(sel), "select field");
  endtask : check_mode

  // Both clock outputs are one system clock, and no runt high pulse reaches them.
  // A pulse cut short by reset is legal, so reset clears the pulse counter.
  always @(posedge core_clk) begin
    if (rst) begin
      hiCnt <= 0;
    end else begin
      if (cpuClk !== periphClk) check(32'(periphClk), 32'(cpuClk), "peripheral clock");
      if (cpuClk === 1'b1) hiCnt <= hiCnt + 1;
      else begin
        if (hiCnt > 0 && hiCnt < 3) check(32'(hiCnt), 32'd3, "high pulse length");
        hiCnt <= 0;
      end
    end
  end

  initial begin
    #(100000 * 50);
    hung("end of run");
  end

  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    rdreg(scs_pkg::OFS_OSC_CTRL);
    check(rd, {25'h0, scs_pkg::FREQ_RESET, 1'b0, scs_pkg::SCS_RESET}, "ctrl reset");
    rdreg(scs_pkg::OFS_T1_CTRL);
    check(rd, 32'h0000_0000, "timer-one reset");
    wr(4'hC, 32'h0000_0003);
    rdreg(4'hC);
    check(rd, 32'h0000_0000, "unmapped read");
    bus(1'b1, scs_pkg::OFS_OSC_CTRL, 32'h0000_0002, 4'h0, rd);
    repeat (30) @(posedge core_clk);
    check_mode(2'd2, 1'b0, 2'd0);
    measure();
    check(32'(per), 32'(2 * (16 - 7)), "two-speed internal period");
    poll_status(scs_pkg::STAT_START_BIT, 1'b1, 8000);
    check_mode(2'd0, 1'b1, 2'd0);
    measure();
    check(32'(per), 32'd8, "primary period");
    for (int s = 2; s < 4; s++) begin
      for (int f = 4; f < 13; f += 8) begin
        wr(scs_pkg::OFS_OSC_CTRL, 32'((f << 3) | s));
        measure();
        check(32'(per), 32'(2 * (16 - f)), "internal period");
        check_mode(2'd2, 1'b0, 2'(s));
      end
    end
    wr(scs_pkg::OFS_T1_CTRL, 32'h0000_0008);
    rdreg(scs_pkg::OFS_OSC_STAT);
    check(32'(secondaryOscOutPinEn), 32'd1, "secondary drive");
    check(32'(rd[1]), 32'd0, "secondary not ready yet");
    poll_status(scs_pkg::STAT_SRDY_BIT, 1'b1, 12000);
    wr(scs_pkg::OFS_OSC_CTRL, 32'h0000_0039);
    measure();
    check(32'(per), 32'd12, "secondary period");
    check_mode(2'd1, 1'b0, 2'd1);
    wr(scs_pkg::OFS_OSC_CTRL, 32'h0000_0038);
    measure();
    check_mode(2'd0, 1'b1, 2'd0);
    wr(scs_pkg::OFS_T1_CTRL, 32'h0000_0000);
    rdreg(scs_pkg::OFS_OSC_STAT);
    check(32'(rd[1]), 32'd0, "ready after disable");
    check(32'(secondaryOscOutPinEn), 32'd0, "secondary drive off");
    primaryStop <= 1'b1;
    poll_status(scs_pkg::STAT_FAIL_BIT, 1'b1, 200);
    check_mode(2'd2, 1'b0, 2'd0);
    measure();
    check(32'(per), 32'd18, "fail-safe internal period");
    wr(scs_pkg::OFS_OSC_CTRL, 32'h0000_0002);
    @(posedge core_clk);
    rst <= 1'b1;
    primaryStop <= 1'b0;
    oscCfg <= scs_pkg::CFG_INTERNAL;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    rdreg(scs_pkg::OFS_OSC_CTRL);
    check(rd, {25'h0, scs_pkg::FREQ_RESET, 1'b0, scs_pkg::SCS_RESET}, "ctrl after reset");
    repeat (30) @(posedge core_clk);
    check_mode(2'd2, 1'b0, 2'd0);
    measure();
    check(32'(per), 32'd18, "configured internal period");
    wrap_up();
  end
endmodule : scs_system_clock_switch_test
